// ===== verilog/mmd_map.svh
// Address map constants for the memory address map decoder.
// Assumes a 40 MHz system clock; included by the router and the decoder top.
//
// Behaviour
// - Indirect upper-half internal accesses reach the upper 128 bytes of RAM.
// - Direct upper-half internal accesses reach the special function space.
// - Lower 128 internal bytes map identically for direct and indirect access.
// - Lowest 32 RAM bytes form four banks of eight registers.
// - Sixteen bytes after the banks are byte and bit addressable.
// - On-chip 8 KB external block repeats every 8 KB across 64 KB.
// - External routing: on-chip only, off-chip only, or split at 8 KB.
// - External memory port runs multiplexed or separate address and data.
// - 128 KB flash: bank select replaces bit 15 in the upper 32 KB program window; the lower 32 KB is fixed.
// - Flash erase clears one whole aligned 1024-byte sector, or 128 bytes in scratch.
// - Flash range 0x1FC00 to 0x1FFFF is reserved from application use.
// - Two 128-byte scratch sectors decode at 0x20000 to 0x200FF.
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

`define MMD_UPPER_BIT      7
`define MMD_BIT_BASE       8'h20
`define MMD_SFR_BIT_MASK   8'hf8
`define MMD_XRAM_SIZE      16'h2000
`define MMD_CODE_WIN_BIT   15
`define MMD_RSVD_LO        18'h1fc00
`define MMD_RSVD_HI        18'h1ffff
`define MMD_SCR_BASE       18'h20000
`define MMD_SECT_MASK      18'h3fc00
`define MMD_SCR_SECT_MASK  18'h3ff80
`define MMD_CLK_PS         25000
`define MMD_EXT_STROBE_NS  50
`define MMD_EXT_STROBE_CYC \
    ((`MMD_EXT_STROBE_NS * 1000 + `MMD_CLK_PS - 1) / `MMD_CLK_PS)

`endif

// ===== verilog/mmd_pkg.sv
// Types shared by the memory address map decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mmd_pkg;

    typedef enum logic [2:0] {
        MMD_K_DIRECT   = 3'h0,
        MMD_K_INDIRECT = 3'h1,
        MMD_K_REGOP    = 3'h2,
        MMD_K_BITOP    = 3'h3,
        MMD_K_XDATA    = 3'h4,
        MMD_K_CODE     = 3'h5,
        MMD_K_ERASE    = 3'h6
    } mmd_kind_t;

    typedef enum logic [1:0] {
        MMD_R_ONCHIP  = 2'h0,
        MMD_R_OFFCHIP = 2'h1,
        MMD_R_SPLIT   = 2'h2
    } mmd_route_t;

    typedef enum logic [2:0] {
        MMD_X_IDLE = 3'b001,
        MMD_X_ADDR = 3'b010,
        MMD_X_STRB = 3'b100
    } mmd_xst_t;

endpackage
`default_nettype wire

// ===== verilog/mmd_xdata_if.sv
// Link between the decoder top and its external data router.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
`default_nettype none
interface mmd_xdata_if;
    import mmd_pkg::*;
    logic              ce;
    logic              req;
    logic [15:0]       addr;
    logic              wr;
    logic [7:0]        wdata;
    mmd_route_t        route;
    logic              mux;
    logic [7:0]        ad_in;
    logic              busy;
    logic              done;
    logic              xram_sel;
    logic [12:0]       xram_addr;
    logic              ale;
    logic [15:0]       ext_addr;
    logic [7:0]        ad_out;
    logic              ad_oe;
    logic              rd_n;
    logic              wr_n;
    logic [7:0]        rdata;

    modport top (output ce, req, addr, wr, wdata, route, mux, ad_in,
                 input busy, done, xram_sel, xram_addr, ale, ext_addr,
                 ad_out, ad_oe, rd_n, wr_n, rdata);
    modport router (input ce, req, addr, wr, wdata, route, mux, ad_in,
                    output busy, done, xram_sel, xram_addr, ale, ext_addr,
                    ad_out, ad_oe, rd_n, wr_n, rdata);
endinterface
`default_nettype wire

// ===== verilog/mmd_xdata_router.sv
// External data router: on-chip block alias and external memory port.
// Assumes requests arrive only while busy is low.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_map.svh"
module mmd_xdata_router (
    input  wire logic    clk_sys_in,
    input  wire logic    nrst_in,
    mmd_xdata_if.router  xif
);
    import mmd_pkg::*;

    typedef struct packed {
        mmd_xst_t    st;
        logic [1:0]  cnt;
        logic        wr;
        logic        busy;
        logic        done;
        logic        xram_sel;
        logic [12:0] xram_addr;
        logic        ale;
        logic [15:0] ext_addr;
        logic [7:0]  ad_out;
        logic [7:0]  wdata;
        logic        ad_oe;
        logic        rd_n;
        logic        wr_n;
        logic [7:0]  rdata;
    } mmd_xstate_t;

    localparam mmd_xstate_t RST = '{st: MMD_X_IDLE, rd_n: 1'b1,
                                    wr_n: 1'b1, default: '0};
    localparam logic [1:0] STRB_LAST = 2'(`MMD_EXT_STROBE_CYC - 1);

    mmd_xstate_t r_reg;
    mmd_xstate_t r_next;
    logic        onchip;

    // Routing is sampled with the request, so a new setting only
    // affects accesses taken after it changes.
    always_comb begin
        onchip = (xif.route == MMD_R_ONCHIP) ||
                 (xif.route == MMD_R_SPLIT &&
                  xif.addr < `MMD_XRAM_SIZE);
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.xram_sel = 1'b0;
        case (r_reg.st)
            MMD_X_IDLE: begin
                if (xif.req) begin
                    r_next.wr = xif.wr;
                    r_next.wdata = xif.wdata;
                    if (onchip) begin
                        // Upper address bits are dropped: the block aliases.
                        r_next.xram_sel = 1'b1;
                        r_next.xram_addr = xif.addr[12:0];
                        r_next.done = 1'b1;
                    end else begin
                        r_next.busy = 1'b1;
                        r_next.ext_addr = xif.addr;
                        if (xif.mux) begin
                            r_next.st = MMD_X_ADDR;
                            r_next.ale = 1'b1;
                            r_next.ad_out = xif.addr[7:0];
                            r_next.ad_oe = 1'b1;
                        end else begin
                            r_next.st = MMD_X_STRB;
                            r_next.cnt = STRB_LAST;
                            r_next.rd_n = xif.wr;
                            r_next.wr_n = !xif.wr;
                            r_next.ad_out = xif.wdata;
                            r_next.ad_oe = xif.wr;
                        end
                    end
                end
            end
            MMD_X_ADDR: begin
                r_next.st = MMD_X_STRB;
                r_next.cnt = STRB_LAST;
                r_next.ale = 1'b0;
                r_next.rd_n = r_reg.wr;
                r_next.wr_n = !r_reg.wr;
                r_next.ad_out = r_reg.wdata;
                r_next.ad_oe = r_reg.wr;
            end
            MMD_X_STRB: begin
                if (r_reg.cnt == 2'd0) begin
                    if (!r_reg.wr) begin
                        r_next.rdata = xif.ad_in;
                    end
                    r_next.st = MMD_X_IDLE;
                    r_next.rd_n = 1'b1;
                    r_next.wr_n = 1'b1;
                    r_next.ad_oe = 1'b0;
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                end else begin
                    r_next.cnt = r_reg.cnt - 2'd1;
                end
            end
            default: r_next = RST;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            r_reg <= RST;
        end else if (xif.ce) begin
            r_reg <= r_next;
        end
    end

    assign xif.busy = r_reg.busy;
    assign xif.done = r_reg.done;
    assign xif.xram_sel = r_reg.xram_sel;
    assign xif.xram_addr = r_reg.xram_addr;
    assign xif.ale = r_reg.ale;
    assign xif.ext_addr = r_reg.ext_addr;
    assign xif.ad_out = r_reg.ad_out;
    assign xif.ad_oe = r_reg.ad_oe;
    assign xif.rd_n = r_reg.rd_n;
    assign xif.wr_n = r_reg.wr_n;
    assign xif.rdata = r_reg.rdata;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in || !xif.ce);

    xram_alias_a: assert property (
        xif.req && !r_reg.busy && xif.route == MMD_R_ONCHIP |=>
        xif.xram_sel && xif.xram_addr == $past(xif.addr[12:0]))
        else $error("on-chip block not aliased");
    split_route_a: assert property (
        xif.req && !r_reg.busy && xif.route == MMD_R_SPLIT &&
        xif.addr >= `MMD_XRAM_SIZE |=> !xif.xram_sel && xif.busy)
        else $error("split mode high address stayed on chip");
    offchip_route_a: assert property (
        xif.req && !r_reg.busy && xif.route == MMD_R_OFFCHIP |=>
        !xif.xram_sel && xif.ext_addr == $past(xif.addr))
        else $error("off-chip route reached the on-chip block");
    mux_phase_a: assert property (
        xif.ale |=> !xif.ale && (!xif.rd_n || !xif.wr_n) &&
        xif.ad_oe == !xif.wr_n ##2 xif.done)
        else $error("multiplexed address phase not followed by strobe");
    cover_mux_rd: cover property (xif.ale ##1 !xif.rd_n);
    cover_alias: cover property (xif.xram_sel && xif.xram_addr != 13'h0);
endmodule
`default_nettype wire

// ===== verilog/mmd_decoder.sv
// Top of the memory address map decoder for the processor core.
// Assumes one access is offered at a time and held off while busy_out.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_map.svh"
module mmd_decoder (
    input  wire logic                clk_sys_in,
    input  wire logic                nrst_in,
    input  wire logic                ce_in,
    input  wire logic                acc_valid_in,
    input  wire mmd_pkg::mmd_kind_t  acc_kind_in,
    input  wire logic                acc_write_in,
    input  wire logic [15:0]         acc_addr_in,
    input  wire logic [7:0]          acc_wdata_in,
    input  wire logic [1:0]          psw_bank_in,
    input  wire logic [1:0]          code_bank_in,
    input  wire logic                code_scratch_in,
    input  wire mmd_pkg::mmd_route_t xroute_mode_in,
    input  wire logic                xmux_mode_in,
    input  wire logic [7:0]          ext_ad_in,
    output logic                     busy_out,
    output logic                     dec_valid_out,
    output logic                     ram_sel_out,
    output logic [7:0]               ram_addr_out,
    output logic                     sfr_sel_out,
    output logic [7:0]               sfr_addr_out,
    output logic [7:0]               bit_mask_out,
    output logic                     flash_sel_out,
    output logic [17:0]              flash_addr_out,
    output logic                     flash_erase_out,
    output logic                     flash_wr_en_out,
    output logic                     rsvd_hit_out,
    output logic                     xram_sel_out,
    output logic [12:0]              xram_addr_out,
    output logic                     x_done_out,
    output logic [7:0]               x_rdata_out,
    output logic                     ext_ale_out,
    output logic [15:0]              ext_addr_out,
    output logic [7:0]               ext_ad_out,
    output logic                     ext_ad_oe_out,
    output logic                     ext_rd_n_out,
    output logic                     ext_wr_n_out
);
    import mmd_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [17:0] mmd_code_addr(input logic scr,
                                                  input logic [1:0] bk,
                                                  input logic [15:0] a);
        if (scr) begin
            return `MMD_SCR_BASE | {10'h000, a[7:0]};
        end
        if (a[`MMD_CODE_WIN_BIT]) begin
            return {1'b0, bk, a[14:0]};
        end
        return {3'b000, a[14:0]};
    endfunction

    function automatic logic mmd_is_rsvd(input logic [17:0] fa);
        return fa >= `MMD_RSVD_LO && fa <= `MMD_RSVD_HI;
    endfunction

    typedef struct packed {
        logic        dec_valid;
        logic        ram_sel;
        logic [7:0]  ram_addr;
        logic        sfr_sel;
        logic [7:0]  sfr_addr;
        logic [7:0]  bit_mask;
        logic        flash_sel;
        logic [17:0] flash_addr;
        logic        flash_erase;
        logic        flash_wr_en;
        logic        rsvd_hit;
    } mmd_dstate_t;

    mmd_dstate_t  r_reg;
    mmd_dstate_t  r_next;
    mmd_xdata_if  xif ();
    logic         take;
    logic [17:0]  fa;
    logic         rsvd;

    assign take = acc_valid_in && !xif.busy;

    // ****************************************
    // Access decode
    // ****************************************
    always_comb begin
        fa = mmd_code_addr(code_scratch_in, code_bank_in, acc_addr_in);
        rsvd = mmd_is_rsvd(fa);
        r_next = r_reg;
        r_next.dec_valid = 1'b0;
        r_next.ram_sel = 1'b0;
        r_next.sfr_sel = 1'b0;
        r_next.flash_sel = 1'b0;
        r_next.flash_erase = 1'b0;
        r_next.flash_wr_en = 1'b0;
        r_next.rsvd_hit = 1'b0;
        r_next.bit_mask = 8'h00;
        if (take && acc_kind_in != MMD_K_XDATA) begin
            r_next.dec_valid = 1'b1;
            case (acc_kind_in)
                MMD_K_DIRECT: begin
                    if (acc_addr_in[`MMD_UPPER_BIT]) begin
                        r_next.sfr_sel = 1'b1;
                        r_next.sfr_addr = acc_addr_in[7:0];
                    end else begin
                        r_next.ram_sel = 1'b1;
                        r_next.ram_addr = acc_addr_in[7:0];
                    end
                end
                MMD_K_INDIRECT: begin
                    // Both halves go to RAM; upper half is never SPECIAL_FUNCTION_SPACE here.
                    r_next.ram_sel = 1'b1;
                    r_next.ram_addr = acc_addr_in[7:0];
                end
                MMD_K_REGOP: begin
                    r_next.ram_sel = 1'b1;
                    r_next.ram_addr = {3'b000, psw_bank_in,
                                       acc_addr_in[2:0]};
                end
                MMD_K_BITOP: begin
                    r_next.bit_mask = 8'h01 << acc_addr_in[2:0];
                    if (acc_addr_in[`MMD_UPPER_BIT]) begin
                        r_next.sfr_sel = 1'b1;
                        r_next.sfr_addr = acc_addr_in[7:0] &
                                          `MMD_SFR_BIT_MASK;
                    end else begin
                        r_next.ram_sel = 1'b1;
                        r_next.ram_addr = `MMD_BIT_BASE +
                                          {4'h0, acc_addr_in[6:3]};
                    end
                end
                MMD_K_CODE: begin
                    r_next.flash_sel = 1'b1;
                    r_next.flash_addr = fa;
                    r_next.rsvd_hit = rsvd;
                    r_next.flash_wr_en = acc_write_in && !rsvd;
                end
                MMD_K_ERASE: begin
                    r_next.flash_sel = 1'b1;
                    r_next.flash_addr = fa & (code_scratch_in ?
                        `MMD_SCR_SECT_MASK : `MMD_SECT_MASK);
                    r_next.rsvd_hit = rsvd;
                    r_next.flash_erase = !rsvd;
                end
                default: r_next.dec_valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            r_reg <= '0;
        end else if (ce_in) begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // External data path
    // ****************************************
    assign xif.ce = ce_in;
    assign xif.req = take && acc_kind_in == MMD_K_XDATA;
    assign xif.addr = acc_addr_in;
    assign xif.wr = acc_write_in;
    assign xif.wdata = acc_wdata_in;
    assign xif.route = xroute_mode_in;
    assign xif.mux = xmux_mode_in;
    assign xif.ad_in = ext_ad_in;

    mmd_xdata_router u_router (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .xif        (xif)
    );

    assign busy_out = xif.busy;
    assign dec_valid_out = r_reg.dec_valid;
    assign ram_sel_out = r_reg.ram_sel;
    assign ram_addr_out = r_reg.ram_addr;
    assign sfr_sel_out = r_reg.sfr_sel;
    assign sfr_addr_out = r_reg.sfr_addr;
    assign bit_mask_out = r_reg.bit_mask;
    assign flash_sel_out = r_reg.flash_sel;
    assign flash_addr_out = r_reg.flash_addr;
    assign flash_erase_out = r_reg.flash_erase;
    assign flash_wr_en_out = r_reg.flash_wr_en;
    assign rsvd_hit_out = r_reg.rsvd_hit;
    assign xram_sel_out = xif.xram_sel;
    assign xram_addr_out = xif.xram_addr;
    assign x_done_out = xif.done;
    assign x_rdata_out = xif.rdata;
    assign ext_ale_out = xif.ale;
    assign ext_addr_out = xif.ext_addr;
    assign ext_ad_out = xif.ad_out;
    assign ext_ad_oe_out = xif.ad_oe;
    assign ext_rd_n_out = xif.rd_n;
    assign ext_wr_n_out = xif.wr_n;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in || !ce_in);

    upper_indirect_a: assert property (
        take && acc_kind_in == MMD_K_INDIRECT && acc_addr_in[7] |=>
        ram_sel_out && !sfr_sel_out &&
        ram_addr_out == $past(acc_addr_in[7:0]))
        else $error("indirect upper access missed upper RAM");
    direct_sfr_a: assert property (
        take && acc_kind_in == MMD_K_DIRECT && acc_addr_in[7] |=>
        sfr_sel_out && !ram_sel_out &&
        sfr_addr_out == $past(acc_addr_in[7:0]))
        else $error("direct upper access missed special function space");
    lower_same_a: assert property (
        take && !acc_addr_in[7] && (acc_kind_in == MMD_K_DIRECT ||
        acc_kind_in == MMD_K_INDIRECT) |=> ram_sel_out &&
        ram_addr_out == $past(acc_addr_in[7:0]))
        else $error("lower RAM mapped differently by mode");
    reg_bank_a: assert property (
        take && acc_kind_in == MMD_K_REGOP |=> ram_sel_out &&
        ram_addr_out == {3'b000, $past(psw_bank_in),
                         $past(acc_addr_in[2:0])})
        else $error("register operand in wrong bank");
    bit_area_a: assert property (
        take && acc_kind_in == MMD_K_BITOP && !acc_addr_in[7] |=>
        ram_addr_out == 8'h20 + {4'h0, $past(acc_addr_in[6:3])} &&
        bit_mask_out == 8'h01 << $past(acc_addr_in[2:0]))
        else $error("bit address decoded wrongly");
    bank_decode_a: assert property (
        take && acc_kind_in == MMD_K_CODE |=> flash_sel_out &&
        flash_addr_out == mmd_code_addr($past(code_scratch_in),
            $past(code_bank_in), $past(acc_addr_in)))
        else $error("program address decoded wrongly");
    erase_align_a: assert property (
        flash_erase_out && !flash_addr_out[17] |->
        flash_addr_out[9:0] == 10'h000)
        else $error("erase not sector aligned");
    reserved_guard_a: assert property (
        flash_sel_out && mmd_is_rsvd(flash_addr_out) |->
        rsvd_hit_out && !flash_erase_out && !flash_wr_en_out)
        else $error("reserved flash was modifiable");
    scratch_map_a: assert property (
        take && acc_kind_in == MMD_K_CODE && code_scratch_in |=>
        flash_addr_out[17:8] == 10'h200)
        else $error("scratch sector outside its window");
    reg_range_a: assert property (
        take && acc_kind_in == MMD_K_REGOP |=> ram_addr_out < 8'h20)
        else $error("register operand outside the banks");
    scratch_erase_a: assert property (
        flash_erase_out && flash_addr_out[17] |->
        flash_addr_out[6:0] == 7'h00)
        else $error("scratch erase not sector aligned");
    xdata_quiet_a: assert property (
        take && acc_kind_in == MMD_K_XDATA |=>
        !dec_valid_out && !ram_sel_out && !flash_sel_out)
        else $error("external access raised an internal select");
    busy_refuse_a: assert property (
        busy_out |=> !dec_valid_out && !xram_sel_out)
        else $error("request taken while the port was busy");
    strobe_excl_a: assert property (
        !ext_rd_n_out |-> ext_wr_n_out)
        else $error("both external strobes active");
    ale_addr_a: assert property (
        ext_ale_out |-> ext_ad_oe_out && ext_ad_out == ext_addr_out[7:0])
        else $error("address phase lost the low address byte");
    cover_rsvd: cover property (rsvd_hit_out && dec_valid_out);
    cover_split_ext: cover property (busy_out && ext_addr_out[13]);
    cover_bank3: cover property (take && acc_kind_in == MMD_K_REGOP &&
                                 psw_bank_in == 2'h3);
endmodule
`default_nettype wire

// ===== sim/mmd_ext_mem.sv
// Behavioural external memory on the far side of the external port.
// Assumes the decoder drives address, strobes and the data enable.
`timescale 1ns/10ps
`default_nettype none
module mmd_ext_mem (
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        rd_n_in,
    input  wire logic        ad_oe_in,
    input  wire logic [7:0]  ad_drv_in,
    output logic      [7:0]  ad_out
);
    logic [7:0] last_reg = 8'h00;

    // An idle bus toggles, so a stale value never passes for read data.
    always_ff @(posedge clk_sys_in) begin
        last_reg <= ad_out;
    end

    always_comb begin
        if (ad_oe_in) begin
            ad_out = ad_drv_in;
        end else if (!rd_n_in) begin
            ad_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5a;
        end else begin
            ad_out = ~last_reg;
        end
    end
endmodule
`default_nettype wire

// ===== sim/test_memory_address_map_decoder.sv
// Self-checking bench for the memory address map decoder.
// Assumes mmd_decoder, its package and the external memory model.
`timescale 1ns/10ps
`default_nettype none
module test_memory_address_map_decoder;
    import mmd_pkg::*;
    logic clk_sys_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, acc_valid_in = 1'b0;
    mmd_kind_t acc_kind_in = MMD_K_DIRECT;
    mmd_route_t xroute_mode_in = MMD_R_ONCHIP;
    logic acc_write_in = 1'b0, code_scratch_in = 1'b0, xmux_mode_in = 1'b0;
    logic [15:0] acc_addr_in = 16'h0000, ext_addr_out, adr1;
    logic [7:0] acc_wdata_in = 8'h00, ext_ad_in, ram_addr_out, sfr_addr_out;
    logic [7:0] bit_mask_out, x_rdata_out, ext_ad_out;
    logic [1:0] psw_bank_in = 2'h0, code_bank_in = 2'h0;
    logic busy_out, dec_valid_out, ram_sel_out, sfr_sel_out, flash_sel_out;
    logic flash_erase_out, flash_wr_en_out, rsvd_hit_out, xram_sel_out;
    logic x_done_out, ext_ale_out, ext_ad_oe_out, ext_rd_n_out, ext_wr_n_out;
    logic [17:0] flash_addr_out;
    logic [12:0] xram_addr_out;
    logic ale1;
    logic [10:0] pin1;
    int error_cnt = 0, compares = 0, seed = 38, n, i, a, b;

    mmd_decoder dut (.clk_sys_in, .nrst_in, .ce_in, .acc_valid_in,
        .acc_kind_in, .acc_write_in, .acc_addr_in, .acc_wdata_in, .psw_bank_in,
        .code_bank_in, .code_scratch_in, .xroute_mode_in, .xmux_mode_in,
        .ext_ad_in, .busy_out, .dec_valid_out, .ram_sel_out, .ram_addr_out,
        .sfr_sel_out, .sfr_addr_out, .bit_mask_out, .flash_sel_out,
        .flash_addr_out, .flash_erase_out, .flash_wr_en_out, .rsvd_hit_out,
        .xram_sel_out, .xram_addr_out, .x_done_out, .x_rdata_out, .ext_ale_out,
        .ext_addr_out, .ext_ad_out, .ext_ad_oe_out, .ext_rd_n_out,
        .ext_wr_n_out);
    mmd_ext_mem mem (.clk_sys_in(clk_sys_in), .addr_in(ext_addr_out),
        .rd_n_in(ext_rd_n_out), .ad_oe_in(ext_ad_oe_out),
        .ad_drv_in(ext_ad_out), .ad_out(ext_ad_in));

    always #12.5 clk_sys_in = ~clk_sys_in;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input mmd_kind_t k, input logic w,
                       input logic [15:0] ad, input logic [1:0] bk,
                       input logic s);
        @(posedge clk_sys_in);
        acc_kind_in <= k;
        {acc_valid_in, acc_write_in, acc_addr_in, psw_bank_in,
         code_bank_in, code_scratch_in} <= {1'b1, w, ad, bk, bk, s};
        @(posedge clk_sys_in);
        acc_valid_in <= 1'b0;
        #1;
    endtask

    // Counts cycles from the taking edge to the done pulse.
    task automatic xacc(input logic [15:0] ad, input logic w,
                        input mmd_route_t r, input logic m);
        @(posedge clk_sys_in);
        acc_kind_in <= MMD_K_XDATA;
        xroute_mode_in <= r;
        {acc_valid_in, acc_write_in, acc_addr_in, xmux_mode_in,
         acc_wdata_in} <= {1'b1, w, ad, m, 8'($random(seed))};
        @(posedge clk_sys_in);
        acc_valid_in <= 1'b0;
        #1;
        n = 1;
        ale1 = ext_ale_out;
        adr1 = ext_addr_out;
        pin1 = {busy_out, ext_ad_oe_out, ext_wr_n_out, ext_ad_out};
        while (x_done_out !== 1'b1 && n < 20) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
    endtask

    task automatic stop_test();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        #1;
        chk(ext_rd_n_out, 1);
        chk(busy_out, 0);
        for (i = 0; i < 16; i++) begin
            a = $random(seed) & 8'hff;
            acc(MMD_K_DIRECT, 0, 16'(a), 0, 0);
            chk({dec_valid_out, sfr_sel_out, ram_sel_out},
                (a >= 128) ? 6 : 5);
            if (a >= 128) chk(sfr_addr_out, a);
            else chk(ram_addr_out, a);
            acc(MMD_K_INDIRECT, 0, 16'(a), 0, 0);
            chk({ram_sel_out, ram_addr_out}, 32'h100 | a);
            b = i & 3;
            acc(MMD_K_REGOP, 0, 16'(a), 2'(b), 0);
            chk(ram_addr_out, b * 8 + (a & 7));
            acc(MMD_K_BITOP, 0, 16'(a), 0, 0);
            chk(bit_mask_out, 1 << (a & 7));
            if (a >= 128) chk(sfr_addr_out, a & 8'hf8);
            else chk(ram_addr_out, 32 + (a >> 3));
            a = $random(seed) & 16'hffff;
            acc(MMD_K_CODE, 0, 16'(a), 2'(b), 0);
            n = (a < 32768) ? a : b * 32768 + (a & 16'h7fff);
            chk(flash_addr_out, n);
            chk(rsvd_hit_out, n >= 32'h1fc00);
            acc(MMD_K_CODE, 0, 16'(a), 2'(b), 1);
            chk(flash_addr_out, 32'h20000 + (a & 8'hff));
        end
        $display("internal and program decode done");
        acc(MMD_K_CODE, 0, 16'hfc10, 3, 0);
        chk({flash_sel_out, rsvd_hit_out}, 3);
        acc(MMD_K_CODE, 1, 16'hfd00, 3, 0);
        chk({flash_wr_en_out, rsvd_hit_out}, 1);
        acc(MMD_K_CODE, 1, 16'h1234, 0, 0);
        chk(flash_wr_en_out, 1);
        acc(MMD_K_ERASE, 1, 16'h8765, 2, 0);
        chk({flash_erase_out, flash_addr_out}, 32'h50400);
        acc(MMD_K_ERASE, 1, 16'hffff, 3, 0);
        chk({flash_erase_out, rsvd_hit_out}, 1);
        $display("flash protection done");
        for (i = 0; i < 6; i++) begin
            a = $random(seed) & 16'hffff;
            xacc(16'(a), 0, MMD_R_ONCHIP, 0);
            chk({n[7:0], xram_sel_out, xram_addr_out},
                32'h6000 | (a & 16'h1fff));
        end
        xacc(16'h1abc, 0, MMD_R_SPLIT, 1);
        chk({n[7:0], xram_sel_out, xram_addr_out}, 32'h7abc);
        xacc(16'h2f31, 0, MMD_R_SPLIT, 1);
        chk({n[3:0], 4'(ale1), adr1}, 32'h412f31);
        chk(pin1, 32'h731);
        chk(x_rdata_out, 8'h31 ^ 8'h2f ^ 8'h5a);
        xacc(16'h0010, 1, MMD_R_OFFCHIP, 0);
        chk({n[3:0], 4'(ale1), adr1}, 32'h300010);
        chk(pin1, 32'h600 | acc_wdata_in);
        xacc(16'h0010, 0, MMD_R_ONCHIP, 0);
        chk({n[7:0], xram_sel_out}, 3);
        $display("external data routing done");
        stop_test();
    end
endmodule
`default_nettype wire
